// ==== logic/ttc_cfg.svh ====
// constants and register map of the temperature threshold compare
// What this block does
// - compare temperature integer part, bits 11 to 4, against low limit
// - low limit is 8-bit signed two's complement, -128 to 127 degrees
// - compare temperature integer part, bits 11 to 4, against high limit
// - high limit is 8-bit signed two's complement, -128 to 127 degrees
// - low limit always readable, writes ignored while write lock active
// - low event when signed temperature integer is below low limit
`ifndef TTC_CFG_SVH
`define TTC_CFG_SVH

// =====================================================================
// register offsets
`define TTC_LOW_LIMIT_OFS 8'h16
`define TTC_HIGH_LIMIT_OFS 8'h17
`define TTC_STATUS_OFS 8'h20
`define TTC_MASK_OFS 8'h21
`define TTC_CTRL_OFS 8'h22
`define TTC_TEMP_OFS 8'h23

// =====================================================================
// field positions
`define TTC_INT_MSB 11
`define TTC_INT_LSB 4
`define TTC_EVT_LOW 0
`define TTC_EVT_HIGH 1

// =====================================================================
// reset values
`define TTC_LIMIT_RST 8'h00
`define TTC_STATUS_RST 2'h0
`define TTC_MASK_RST 2'h0
`define TTC_CTRL_RST 2'h3
`define TTC_RDATA_RST 8'h00

`endif

// ==== logic/ttc_pkg.sv ====
// types shared by the temperature threshold compare modules
package ttc_pkg;

  // signed whole degrees
  typedef logic signed [7:0] ttc_degc_t;

  // two event lanes: low and high
  typedef logic [1:0] ttc_evt_t;

  // top-level state
  typedef struct packed {
    ttc_degc_t low_limit;
    ttc_degc_t high_limit;
    ttc_evt_t ctrl;
    logic [7:0] rdata;
  } ttc_top_s;

  // comparator state
  typedef struct packed {
    logic hit;
    logic rise;
  } ttc_cmp_s;

  // event status state
  typedef struct packed {
    ttc_evt_t status;
    ttc_evt_t mask;
    logic irq;
  } ttc_stat_s;

endpackage

// ==== logic/ttc_if.sv ====
// carriers between the top and its comparator and status modules
`timescale 1ns/1ps

// =====================================================================
// one limit comparator
interface ttc_cmp_if import ttc_pkg::*; ();
  ttc_degc_t temp_int;
  ttc_degc_t limit;
  logic enable;
  logic hit;
  logic rise;
  modport cmp (input temp_int, input limit, input enable,
               output hit, output rise);
  modport ctl (output temp_int, output limit, output enable,
               input hit, input rise);
endinterface

// =====================================================================
// sticky event status and mask
interface ttc_stat_if import ttc_pkg::*; ();
  ttc_evt_t set;
  logic wr_status;
  logic wr_mask;
  ttc_evt_t wdata;
  ttc_evt_t status;
  ttc_evt_t mask;
  logic irq;
  modport stat (input set, input wr_status, input wr_mask, input wdata,
                output status, output mask, output irq);
  modport ctl (output set, output wr_status, output wr_mask,
               output wdata, input status, input mask, input irq);
endinterface

// ==== logic/ttc_limit_cmp.sv ====
// signed limit comparator with crossing pulse
`timescale 1ns/1ps
`include "ttc_cfg.svh"

module ttc_limit_cmp import ttc_pkg::*; #(
  parameter bit ABOVE = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // compare lane
  ttc_cmp_if.cmp lane
);

  ttc_cmp_s s;
  ttc_cmp_s n;

  // =====================================================================
  // compare
  always_comb begin
    n = s;
    if (ABOVE) begin
      n.hit = lane.enable && (lane.temp_int > lane.limit);
    end else begin
      n.hit = lane.enable && (lane.temp_int < lane.limit);
    end
    n.rise = n.hit && !s.hit;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{hit: 1'b0, rise: 1'b0};
    end else begin
      s <= n;
    end
  end

  assign lane.hit = s.hit;
  assign lane.rise = s.rise;

  rise_single_a: assert property (@(posedge clk) disable iff (!rst_b)
    s.rise |=> !s.rise)
    else $error("crossing pulse longer than one cycle");

endmodule

// ==== logic/ttc_evt_stat.sv ====
// sticky event status, mask and interrupt level
`timescale 1ns/1ps
`include "ttc_cfg.svh"

module ttc_evt_stat import ttc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // status lane
  ttc_stat_if.stat st
);

  ttc_stat_s s;
  ttc_stat_s n;

  // =====================================================================
  // write one to clear, set wins
  always_comb begin
    n = s;
    if (st.wr_status) begin
      n.status = s.status & ~st.wdata;
    end
    n.status = n.status | st.set;
    if (st.wr_mask) begin
      n.mask = st.wdata;
    end
    n.irq = |(n.status & n.mask);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{status: `TTC_STATUS_RST, mask: `TTC_MASK_RST, irq: 1'b0};
    end else begin
      s <= n;
    end
  end

  assign st.status = s.status;
  assign st.mask = s.mask;
  assign st.irq = s.irq;

  set_wins_a: assert property (@(posedge clk) disable iff (!rst_b)
    st.set[`TTC_EVT_LOW] |=> s.status[`TTC_EVT_LOW])
    else $error("low event lost against a clear");

endmodule

// ==== logic/ttc_top.sv ====
// temperature threshold compare: limit registers, compare, events
`timescale 1ns/1ps
`include "ttc_cfg.svh"

module ttc_top import ttc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // temperature reading and write lock
  input wire logic [11:0] temp_value,
  input wire logic write_lock,
  // events
  output logic low_event,
  output logic high_event,
  output logic irq
);

  ttc_top_s s;
  ttc_top_s n;
  ttc_degc_t temp_int;

  ttc_cmp_if low_if ();
  ttc_cmp_if high_if ();
  ttc_stat_if stat_if ();

  // =====================================================================
  // temperature integer part
  assign temp_int = temp_value[`TTC_INT_MSB:`TTC_INT_LSB];

  // =====================================================================
  // comparators
  assign low_if.temp_int = temp_int;
  assign low_if.limit = s.low_limit;
  assign low_if.enable = s.ctrl[`TTC_EVT_LOW];

  assign high_if.temp_int = temp_int;
  assign high_if.limit = s.high_limit;
  assign high_if.enable = s.ctrl[`TTC_EVT_HIGH];

  ttc_limit_cmp #(
    .ABOVE(1'b0)
  ) u_low_cmp (
    .clk(clk),
    .rst_b(rst_b),
    .lane(low_if)
  );

  ttc_limit_cmp #(
    .ABOVE(1'b1)
  ) u_high_cmp (
    .clk(clk),
    .rst_b(rst_b),
    .lane(high_if)
  );

  // =====================================================================
  // event status
  assign stat_if.set = {high_if.rise, low_if.rise};
  assign stat_if.wr_status = reg_wr && (reg_addr == `TTC_STATUS_OFS);
  assign stat_if.wr_mask = reg_wr && (reg_addr == `TTC_MASK_OFS);
  assign stat_if.wdata = reg_wdata[1:0];

  ttc_evt_stat u_stat (
    .clk(clk),
    .rst_b(rst_b),
    .st(stat_if)
  );

  // =====================================================================
  // register writes and reads
  always_comb begin
    n = s;
    if (reg_wr) begin
      if (reg_addr == `TTC_LOW_LIMIT_OFS) begin
        if (!write_lock) begin
          n.low_limit = reg_wdata;
        end
      end else if (reg_addr == `TTC_HIGH_LIMIT_OFS) begin
        if (!write_lock) begin
          n.high_limit = reg_wdata;
        end
      end else if (reg_addr == `TTC_CTRL_OFS) begin
        n.ctrl = reg_wdata[1:0];
      end
    end
    n.rdata = `TTC_RDATA_RST;
    if (reg_rd) begin
      if (reg_addr == `TTC_LOW_LIMIT_OFS) begin
        n.rdata = s.low_limit;
      end else if (reg_addr == `TTC_HIGH_LIMIT_OFS) begin
        n.rdata = s.high_limit;
      end else if (reg_addr == `TTC_STATUS_OFS) begin
        n.rdata = {6'h00, stat_if.status};
      end else if (reg_addr == `TTC_MASK_OFS) begin
        n.rdata = {6'h00, stat_if.mask};
      end else if (reg_addr == `TTC_CTRL_OFS) begin
        n.rdata = {6'h00, s.ctrl};
      end else if (reg_addr == `TTC_TEMP_OFS) begin
        n.rdata = temp_int;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{low_limit: `TTC_LIMIT_RST, high_limit: `TTC_LIMIT_RST,
             ctrl: `TTC_CTRL_RST, rdata: `TTC_RDATA_RST};
    end else begin
      s <= n;
    end
  end

  // =====================================================================
  // outputs
  assign reg_rdata = s.rdata;
  assign low_event = low_if.rise;
  assign high_event = high_if.rise;
  assign irq = stat_if.irq;

  // =====================================================================
  // checks: comparison
  low_compare_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    $past(rst_b) |->
      low_if.hit == ($past(s.ctrl[`TTC_EVT_LOW]) &&
      ($signed($past(temp_value[`TTC_INT_MSB:`TTC_INT_LSB])) <
       $signed($past(s.low_limit)))))
    else $error("low compare result wrong");

  high_compare_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    $past(rst_b) |->
      high_if.hit == ($past(s.ctrl[`TTC_EVT_HIGH]) &&
      ($signed($past(temp_value[`TTC_INT_MSB:`TTC_INT_LSB])) >
       $signed($past(s.high_limit)))))
    else $error("high compare result wrong");

  // =====================================================================
  // checks: signed limit range, low limit store and high limit lock
  low_floor_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (s.low_limit == 8'h80) |=> !low_if.hit)
    else $error("reading below the -128 low limit");

  low_store_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (reg_wr && !write_lock && reg_addr == `TTC_LOW_LIMIT_OFS) |=>
      s.low_limit == $past(reg_wdata))
    else $error("low limit not stored");

  high_ceiling_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (s.high_limit == 8'h7F) |=> !high_if.hit)
    else $error("reading above the 127 high limit");

  high_lock_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (reg_wr && write_lock && reg_addr == `TTC_HIGH_LIMIT_OFS) |=>
      $stable(s.high_limit))
    else $error("locked high limit changed");

  // =====================================================================
  // checks: lock and readback
  low_lock_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (reg_wr && write_lock && reg_addr == `TTC_LOW_LIMIT_OFS) |=>
      $stable(s.low_limit))
    else $error("locked low limit changed");

  low_read_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (reg_rd && reg_addr == `TTC_LOW_LIMIT_OFS) |=>
      reg_rdata == $past(s.low_limit))
    else $error("low limit readback wrong");

  read_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside the read answer cycle");

  // =====================================================================
  // checks: events
  low_event_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    low_event |-> low_if.hit && !$past(low_if.hit))
    else $error("low event without a fresh crossing");

  low_sticky_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    low_event |=> stat_if.status[`TTC_EVT_LOW])
    else $error("low event not latched");

  high_event_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (high_if.hit && !$past(high_if.hit) && $past(rst_b)) |-> high_event)
    else $error("high crossing gave no event");

  high_signed_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    ($signed(temp_int) == -8'sd128 && s.high_limit == 8'h00) |=>
      !high_if.hit)
    else $error("high compare treated reading as unsigned");

  irq_level_a: assert property (@(posedge clk) disable iff (!rst_b)
    (stat_if.status == 2'h0) |-> !irq)
    else $error("interrupt with no status bit set");

  irq_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
    irq |-> |(stat_if.status & stat_if.mask))
    else $error("interrupt with every set bit masked");

  status_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    (stat_if.status[`TTC_EVT_LOW] &&
     !(reg_wr && reg_addr == `TTC_STATUS_OFS && reg_wdata[`TTC_EVT_LOW])) |=>
      stat_if.status[`TTC_EVT_LOW])
    else $error("low status bit lost without a clear");

  high_sticky_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    high_event |=> stat_if.status[`TTC_EVT_HIGH])
    else $error("high event not latched");

  low_cross_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (low_if.hit && !$past(low_if.hit) && $past(rst_b)) |-> low_event)
    else $error("low crossing gave no event");

  high_fresh_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    high_event |-> high_if.hit && !$past(high_if.hit))
    else $error("high event without a fresh crossing");

  low_off_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    !s.ctrl[`TTC_EVT_LOW] |=> !low_if.hit)
    else $error("low compare active while disabled");

  high_off_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    !s.ctrl[`TTC_EVT_HIGH] |=> !high_if.hit)
    else $error("high compare active while disabled");

  low_clear_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (reg_wr && reg_addr == `TTC_STATUS_OFS && reg_wdata[`TTC_EVT_LOW] &&
     !low_event) |=> !stat_if.status[`TTC_EVT_LOW])
    else $error("low status bit not cleared");

  high_clear_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (reg_wr && reg_addr == `TTC_STATUS_OFS && reg_wdata[`TTC_EVT_HIGH] &&
     !high_event) |=> !stat_if.status[`TTC_EVT_HIGH])
    else $error("high status bit not cleared");

  // =====================================================================
  // checks: register stores
  high_store_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (reg_wr && !write_lock && reg_addr == `TTC_HIGH_LIMIT_OFS) |=>
      s.high_limit == $past(reg_wdata))
    else $error("high limit not stored");

  low_keep_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    !(reg_wr && reg_addr == `TTC_LOW_LIMIT_OFS) |=> $stable(s.low_limit))
    else $error("low limit changed without a write");

  high_keep_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    !(reg_wr && reg_addr == `TTC_HIGH_LIMIT_OFS) |=> $stable(s.high_limit))
    else $error("high limit changed without a write");

  mask_store_a: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_wr && reg_addr == `TTC_MASK_OFS) |=>
      stat_if.mask == $past(reg_wdata[1:0]))
    else $error("mask not stored");

  ctrl_store_a: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_wr && reg_addr == `TTC_CTRL_OFS) |=>
      s.ctrl == $past(reg_wdata[1:0]))
    else $error("compare enables not stored");

  // =====================================================================
  // checks: readback of the other registers
  high_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_rd && reg_addr == `TTC_HIGH_LIMIT_OFS) |=>
      reg_rdata == $past(s.high_limit))
    else $error("high limit readback wrong");

  status_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_rd && reg_addr == `TTC_STATUS_OFS) |=>
      reg_rdata == {6'h00, $past(stat_if.status)})
    else $error("status readback wrong");

  ctrl_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_rd && reg_addr == `TTC_CTRL_OFS) |=>
      reg_rdata == {6'h00, $past(s.ctrl)})
    else $error("compare enable readback wrong");

  temp_read_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (reg_rd && reg_addr == `TTC_TEMP_OFS) |=>
      reg_rdata == $past(temp_value[`TTC_INT_MSB:`TTC_INT_LSB]))
    else $error("temperature integer readback wrong");

  unmapped_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_rd && reg_addr > `TTC_TEMP_OFS) |=> reg_rdata == 8'h00)
    else $error("unmapped read returned data");

endmodule

// ==== test/ttc_top_test.sv ====
// self-checking bench of the temperature threshold compare
`timescale 1ns/1ps
`include "ttc_cfg.svh"

module ttc_top_test;
  // =====================================================================
  // signals and counters
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [11:0] temp_value = 12'h000;
  logic write_lock = 1'b0;
  logic low_event;
  logic high_event;
  logic irq;
  integer err_total = 0;
  integer compares = 0;
  integer seed = 12604;
  integer cycles = 0;
  integer n_low = 0;
  integer n_high = 0;
  integer bl;
  integer bh;
  logic [7:0] rd_val;
  logic [7:0] t, l, h, d;
  logic [1:0] m, c, e;
  logic [7:0] rst_addr [5] = '{8'h16, 8'h17, 8'h20, 8'h21, 8'h22};
  logic [7:0] rst_exp [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
  logic [23:0] corner [7] = '{24'h80807F, 24'h80817F, 24'h7F807E,
                              24'h000000, 24'hFF00FE, 24'h010200,
                              24'h808000};

  always #5 clk = ~clk;

  ttc_top dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .temp_value(temp_value),
    .write_lock(write_lock), .low_event(low_event),
    .high_event(high_event), .irq(irq));

  // =====================================================================
  // event counting and timeout
  always @(negedge clk) begin
    cycles = cycles + 1;
    if (low_event === 1'b1) n_low = n_low + 1;
    if (high_event === 1'b1) n_high = n_high + 1;
    if (cycles == 5000) begin
      err_total = err_total + 1;
      end_of_test();
    end
  end

  // =====================================================================
  // expectation, compares and bus tasks
  function automatic logic [1:0] exp_evt(input logic signed [7:0] tv,
      input logic signed [7:0] lv, input logic signed [7:0] hv);
    exp_evt = {tv > hv, tv < lv};
  endfunction

  task automatic chk_byte(input string what, input logic [7:0] exp,
                          input logic [7:0] got);
    compares = compares + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp,
                         input logic got);
    compares = compares + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] dv);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= dv;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] dv);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    dv = reg_rdata;
  endtask

  // write then read back with no gap between strobes
  task automatic rw_check(input logic [7:0] a, input logic [7:0] dv,
                          input logic [7:0] exp);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= dv;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk_byte("limit readback", exp, reg_rdata);
  endtask

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // =====================================================================
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      reg_read(rst_addr[i], rd_val);
      chk_byte("reset value", rst_exp[i], rd_val);
    end
    chk_bit("irq at reset", 1'b0, irq);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      write_lock <= 1'b0;
      rw_check(`TTC_LOW_LIMIT_OFS, d, d);
      rw_check(`TTC_HIGH_LIMIT_OFS, ~d, ~d);
      write_lock <= 1'b1;
      rw_check(`TTC_LOW_LIMIT_OFS, d ^ 8'h5A, d);
      rw_check(`TTC_HIGH_LIMIT_OFS, d, ~d);
    end
    write_lock <= 1'b0;
    $display("test lock done");
    for (int i = 0; i < 30; i++) begin
      if (i < 7) begin
        {t, l, h} = corner[i];
        c = 2'h3;
      end else begin
        {t, l, h} = 24'($random(seed));
        c = 2'($random(seed));
      end
      m = 2'($random(seed));
      reg_write(`TTC_CTRL_OFS, 8'h00);
      reg_write(`TTC_STATUS_OFS, 8'h03);
      reg_write(`TTC_LOW_LIMIT_OFS, l);
      reg_write(`TTC_HIGH_LIMIT_OFS, h);
      temp_value <= {t, 4'($random(seed))};
      reg_write(`TTC_MASK_OFS, {6'h00, m});
      bl = n_low;
      bh = n_high;
      reg_write(`TTC_CTRL_OFS, {6'h00, c});
      repeat (4) @(posedge clk);
      e = exp_evt(t, l, h) & c;
      chk_byte("low events", {7'h00, e[0]}, 8'(n_low - bl));
      chk_byte("high events", {7'h00, e[1]}, 8'(n_high - bh));
      reg_read(`TTC_STATUS_OFS, rd_val);
      chk_byte("status", {6'h00, e}, rd_val);
      chk_bit("irq", |(e & m), irq);
      reg_read(`TTC_TEMP_OFS, rd_val);
      chk_byte("temp integer", t, rd_val);
      reg_write(`TTC_STATUS_OFS, 8'h03);
      reg_read(`TTC_STATUS_OFS, rd_val);
      chk_byte("status cleared", 8'h00, rd_val);
      chk_bit("irq cleared", 1'b0, irq);
    end
    $display("test compare done");
    reg_write(8'h30, 8'hA5);
    reg_read(8'h30, rd_val);
    chk_byte("unmapped read", 8'h00, rd_val);
    reg_read(`TTC_LOW_LIMIT_OFS, rd_val);
    chk_byte("low limit kept", l, rd_val);
    @(posedge clk);
    #1;
    chk_byte("read data after", 8'h00, reg_rdata);
    $display("test unmapped done");
    end_of_test();
  end
endmodule
